// ---- core/cbrop_pkg.sv ----
// ==========================================================
// shared constants for the compare / bcd / rotate datapath
package cbrop_pkg;
   // register bus map (byte-free word addresses)
   localparam int ADDR_W = 9;
   localparam logic [8:0] OFS_WORK = 9'h000;
   localparam logic [8:0] OFS_STAT = 9'h001;
   localparam logic [8:0] OFS_FILE_BASE = 9'h100;
   localparam int FILE_SEL_BIT = 8;
   // status register fields
   localparam int STAT_CARRY = 0;
   localparam int STAT_DIGIT = 1;
   localparam int STAT_BUSY = 2;
   localparam int STAT_SKIP = 3;
   localparam logic [7:0] WORK_RESET = 8'h00;
   // instruction encodings, bits 15:9 of the instruction word
   localparam logic [6:0] OPC_CMP_LT = 7'h18;
   localparam logic [6:0] OPC_DADJ = 7'h17;
   localparam logic [6:0] OPC_ROT_L = 7'h11;
   localparam logic [6:0] OPC_ROT_RC = 7'h0c;
   localparam int DEST_BIT = 8;
   // bcd correction figures
   localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
   localparam logic [4:0] BCD_FIX = 5'h06;
   // file register space
   localparam int FILE_DEPTH = 256;
   localparam int FILE_AW = 8;
   typedef enum logic [2:0] {
      CBROP_IDLE = 3'b000,
      CBROP_Q1 = 3'b001,
      CBROP_Q2 = 3'b010,
      CBROP_Q3 = 3'b011,
      CBROP_Q4 = 3'b100
   } cbrop_phase_type;
   typedef enum logic [2:0] {
      CBROP_OP_NOP = 3'b000,
      CBROP_OP_CMP = 3'b001,
      CBROP_OP_DAW = 3'b010,
      CBROP_OP_RLN = 3'b011,
      CBROP_OP_RRC = 3'b100
   } cbrop_op_type;
endpackage : cbrop_pkg

// ---- core/cbrop_fmem.sv ----
`timescale 1ns/1ps
// ==========================================================
// file register store: one write port, two registered read ports
module cbrop_fmem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [AW-1:0] raddr_a_i,
   output logic [WIDTH-1:0] rdata_a_o,
   input wire logic [AW-1:0] raddr_b_i,
   output logic [WIDTH-1:0] rdata_b_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   // refuse shapes the address cannot cover
   initial begin
      if (DEPTH > (1 << AW) || WIDTH < 1) begin
         $error("cbrop_fmem: depth does not fit address width");
      end
   end

   // write port
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // registered read ports, no reset on data
   always_ff @(posedge clk_i) begin
      rdata_a_o <= mem[raddr_a_i];
      rdata_b_o <= mem[raddr_b_i];
   end
endmodule : cbrop_fmem

// ---- core/cbrop_core.sv ----
`timescale 1ns/1ps
module cbrop_core
   import cbrop_pkg::*;
#(
   parameter int DATA_W = 8
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic [15:0] INSTR_I,
   input wire logic INSTR_VALID_I,
   output logic INSTR_READY_O,
   output logic DONE_O,
   output logic SKIP_O,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O
);
   // ==========================================================
   // elaboration check
   initial begin
      if (DATA_W != 8) begin
         $error("cbrop_core: datapath is fixed at eight bits");
      end
   end

   // ==========================================================
   // reset release
   logic rst_meta_n;
   logic rst_n;
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // ==========================================================
   // helpers
   // one bcd digit correction, carry out in bit 4
   function automatic logic [4:0] bcd_digit(input logic [3:0] d, input logic force_fix);
      logic [4:0] s;
      s = {1'b0, d};
      if (d > BCD_MAX_DIGIT || force_fix) begin
         s = s + BCD_FIX;
      end
      return s;
   endfunction : bcd_digit

   function automatic cbrop_op_type decode_op(input logic [6:0] opc);
      cbrop_op_type op;
      op = CBROP_OP_NOP;
      if (opc == OPC_CMP_LT) op = CBROP_OP_CMP;
      else if (opc == OPC_DADJ) op = CBROP_OP_DAW;
      else if (opc == OPC_ROT_L) op = CBROP_OP_RLN;
      else if (opc == OPC_ROT_RC) op = CBROP_OP_RRC;
      return op;
   endfunction : decode_op

   // ==========================================================
   // state
   cbrop_phase_type phase;
   logic [15:0] instr;
   cbrop_op_type op;
   logic [FILE_AW-1:0] fsel;
   logic dest;
   logic [7:0] working_register;
   logic carry_flag;
   logic digit_carry_flag;
   logic skip_pending;
   logic squash;
   logic [7:0] result;
   logic next_carry;
   logic is_less;
   logic [7:0] fdata;
   logic [7:0] bus_fdata;
   logic take;

   assign INSTR_READY_O = (phase == CBROP_IDLE) || (phase == CBROP_Q4);
   assign take = INSTR_READY_O && INSTR_VALID_I;

   // ==========================================================
   // phase sequencer
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         phase <= CBROP_IDLE;
      end else begin
         unique case (phase)
            CBROP_IDLE: phase <= take ? CBROP_Q1 : CBROP_IDLE;
            CBROP_Q1: phase <= CBROP_Q2;
            CBROP_Q2: phase <= CBROP_Q3;
            CBROP_Q3: phase <= CBROP_Q4;
            CBROP_Q4: phase <= take ? CBROP_Q1 : CBROP_IDLE;
            default: phase <= CBROP_IDLE;
         endcase
      end
   end

   // instruction latch and squash of a skipped instruction
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         instr <= 16'h0000;
         squash <= 1'b0;
      end else if (take) begin
         instr <= INSTR_I;
         squash <= skip_pending || (phase == CBROP_Q4 && op == CBROP_OP_CMP && is_less
            && !squash);
      end
   end

   // q1 decode of opcode, file select and destination
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         op <= CBROP_OP_NOP;
         fsel <= '0;
         dest <= 1'b0;
      end else if (phase == CBROP_Q1) begin
         op <= squash ? CBROP_OP_NOP : decode_op(instr[15:9]);
         fsel <= instr[FILE_AW-1:0];
         dest <= instr[DEST_BIT];
      end
   end

   // ==========================================================
   // q3 execute; both bcd digits corrected side by side
   logic [4:0] lo;
   logic [4:0] hi;
   assign lo = bcd_digit(working_register[3:0], digit_carry_flag);
   assign hi = bcd_digit(working_register[7:4], carry_flag);
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         result <= 8'h00;
         next_carry <= 1'b0;
         is_less <= 1'b0;
      end else if (phase == CBROP_Q3) begin
         is_less <= (fdata < working_register);
         unique case (op)
            CBROP_OP_DAW: begin
               result <= {hi[3:0], lo[3:0]};
               next_carry <= hi[4] | carry_flag;
            end
            CBROP_OP_RLN: begin
               result <= {fdata[6:0], fdata[7]};
               next_carry <= carry_flag;
            end
            CBROP_OP_RRC: begin
               result <= {carry_flag, fdata[7:1]};
               next_carry <= fdata[0];
            end
            CBROP_OP_CMP, CBROP_OP_NOP: begin
               result <= fdata;
               next_carry <= carry_flag;
            end
         endcase
      end
   end

   // ==========================================================
   // q4 write of destinations and flags
   logic core_we;
   logic wr_work;
   assign core_we = (phase == CBROP_Q4) && ((op == CBROP_OP_DAW)
      || ((op == CBROP_OP_RLN || op == CBROP_OP_RRC) && dest));
   assign wr_work = (phase == CBROP_Q4) && ((op == CBROP_OP_DAW && !dest)
      || ((op == CBROP_OP_RLN || op == CBROP_OP_RRC) && !dest));

   // working register: core write beats a bus write
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         working_register <= WORK_RESET;
      end else if (wr_work) begin
         working_register <= result;
      end else if (WR_I && ADDR_I == OFS_WORK) begin
         working_register <= WDATA_I;
      end
   end

   // carry flags; compare and left rotate leave them alone
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         carry_flag <= 1'b0;
         digit_carry_flag <= 1'b0;
      end else if (phase == CBROP_Q4 && (op == CBROP_OP_DAW || op == CBROP_OP_RRC)) begin
         carry_flag <= next_carry;
      end else if (WR_I && ADDR_I == OFS_STAT) begin
         carry_flag <= WDATA_I[STAT_CARRY];
         digit_carry_flag <= WDATA_I[STAT_DIGIT];
      end
   end

   // skip request: set on a taken compare, cleared when next instr is taken
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         skip_pending <= 1'b0;
      end else if (phase == CBROP_Q4 && op == CBROP_OP_CMP && is_less && !take) begin
         skip_pending <= 1'b1;
      end else if (take) begin
         skip_pending <= 1'b0;
      end
   end

   // completion pulses; compare writes nothing
   assign DONE_O = (phase == CBROP_Q4);
   assign SKIP_O = (phase == CBROP_Q4) && (op == CBROP_OP_CMP) && is_less;

   // ==========================================================
   // file register store
   logic bus_fwe;
   assign bus_fwe = WR_I && ADDR_I[FILE_SEL_BIT] && !core_we;

   cbrop_fmem #(
      .WIDTH(8),
      .DEPTH(FILE_DEPTH),
      .AW(FILE_AW)
   ) cbrop_fmem_i (
      .clk_i(CORE_CLK_I),
      .we_i(core_we || bus_fwe),
      .waddr_i(core_we ? fsel : ADDR_I[FILE_AW-1:0]),
      .wdata_i(core_we ? result : WDATA_I),
      .raddr_a_i(fsel), // q2 read, data valid in q3
      .rdata_a_o(fdata),
      .raddr_b_i(ADDR_I[FILE_AW-1:0]),
      .rdata_b_o(bus_fdata)
   );

   // ==========================================================
   // bus read path, data one cycle after the strobe
   logic rd_pend;
   logic rd_file;
   logic [7:0] rd_reg;
   always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend <= 1'b0;
         rd_file <= 1'b0;
         rd_reg <= 8'h00;
      end else begin
         rd_pend <= RD_I;
         rd_file <= ADDR_I[FILE_SEL_BIT];
         if (ADDR_I == OFS_WORK) begin
            rd_reg <= working_register;
         end else if (ADDR_I == OFS_STAT) begin
            rd_reg <= 8'h00; // spare status bits read zero
            rd_reg[STAT_CARRY] <= carry_flag;
            rd_reg[STAT_DIGIT] <= digit_carry_flag;
            rd_reg[STAT_BUSY] <= (phase != CBROP_IDLE);
            rd_reg[STAT_SKIP] <= skip_pending;
         end else begin
            rd_reg <= 8'h00; // unmapped reads zero
         end
      end
   end

   assign RDATA_O = !rd_pend ? 8'h00 : (rd_file ? bus_fdata : rd_reg);
endmodule : cbrop_core

// ---- bench/cbrop_seq_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// sequencer stand-in: offers a word and holds it until taken
module cbrop_seq_model (
   input wire logic clk_i,
   input wire logic ready_i,
   output logic [15:0] instr_o,
   output logic valid_o
);
   // idle at time zero
   initial begin
      instr_o = 16'h0000;
      valid_o = 1'b0;
   end
   // offer a word, return at the edge that takes it
   task automatic issue(input logic [15:0] word);
      instr_o <= word;
      valid_o <= 1'b1;
      do @(posedge clk_i); while (ready_i !== 1'b1);
   endtask : issue
   // withdraw; a released word never shows its old value
   task automatic release_bus;
      instr_o <= ~instr_o;
      valid_o <= 1'b0;
   endtask : release_bus
endmodule : cbrop_seq_model

// ---- bench/cbrop_core_checker.sv ----
`timescale 1ns/1ps
// ==========================================================
// port checker
module cbrop_core_checker
   import cbrop_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic [15:0] INSTR_I,
   input wire logic INSTR_VALID_I,
   input wire logic INSTR_READY_O,
   input wire logic DONE_O,
   input wire logic SKIP_O
);
   logic take;
   logic [3:0] cmp_pipe;
   assign take = INSTR_VALID_I && INSTR_READY_O;
   // compares in flight, one stage per phase
   always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cmp_pipe <= 4'h0;
      end else begin
         cmp_pipe <= {cmp_pipe[2:0], take && INSTR_I[15:9] == OPC_CMP_LT};
      end
   end
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);
   take_done_a: assert property (take |-> ##4 DONE_O) else $error("done missing");
   done_cause_a: assert property (DONE_O |-> $past(take, 4)) else $error("stray done");
   ready_drop_a: assert property (take |=> !INSTR_READY_O [*3]) else $error("ready");
   done_gap_a: assert property (DONE_O |=> !DONE_O [*3]) else $error("done gap");
   ready_q4_a: assert property (DONE_O |-> INSTR_READY_O) else $error("no ready");
   idle_ready_a: assert property (DONE_O && !take |=> INSTR_READY_O && !DONE_O)
      else $error("no idle");
   skip_done_a: assert property (SKIP_O |-> DONE_O) else $error("skip off q4");
   skip_nop_a: assert property (SKIP_O |=> !SKIP_O [*4]) else $error("skip in nop");
   skip_cmp_a: assert property (SKIP_O |-> cmp_pipe[3]) else $error("skip no cmp");
endmodule : cbrop_core_checker
bind cbrop_core cbrop_core_checker cbrop_core_checker_i (.CORE_CLK_I(CORE_CLK_I),
   .RST_N_I(RST_N_I), .INSTR_I(INSTR_I), .INSTR_VALID_I(INSTR_VALID_I),
   .INSTR_READY_O(INSTR_READY_O), .DONE_O(DONE_O), .SKIP_O(SKIP_O));

// ---- bench/cbrop_core_bench.sv ----
`timescale 1ns/1ps
// ==========================================================
// self-checking bench
module cbrop_core_bench
   import cbrop_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] instr;
   logic valid, ready, done, skip, c, dc;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_q = 1'b0;
   logic skp = 1'b0;
   logic [ADDR_W-1:0] addr = 9'h000;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, w;
   logic [7:0] fm [256];
   logic [15:0] lf = 16'hc131;
   logic [7:0] exp_rd [$];
   logic exp_sk [$];
   int n_fail = 0;
   int check_count = 0;
   always #4 clk = ~clk;
   cbrop_core cbrop_core_i (.CORE_CLK_I(clk), .RST_N_I(rst_n), .INSTR_I(instr),
      .INSTR_VALID_I(valid), .INSTR_READY_O(ready), .DONE_O(done), .SKIP_O(skip),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
   cbrop_seq_model cbrop_seq_model_i (.clk_i(clk), .ready_i(ready), .instr_o(instr),
      .valid_o(valid));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      check_count++;
      if (seen !== want) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic wrap_up;
      if (n_fail == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   // lfsr step, low byte handed out
   function automatic logic [7:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return lf[7:0];
   endfunction : rnd
   // one bus cycle; strobes stay up for back-to-back use
   task automatic bus(input logic we, input logic [8:0] a, input logic [7:0] d);
      wr <= we;
      rd <= !we;
      addr <= a;
      wdata <= d;
      @(posedge clk);
   endtask : bus
   task automatic quiet;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask : quiet
   task automatic rdx(input logic [8:0] a, input logic [7:0] e);
      exp_rd.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask : rdx
   // predict one instruction, then offer it
   task automatic ex(input logic [1:0] k, input logic s, input logic [7:0] f);
      logic [7:0] r;
      logic [4:0] h;
      logic [3:0] l;
      r = fm[f];
      if (skp) begin
         skp = 1'b0;
         exp_sk.push_back(1'b0);
      end else begin
         skp = k == 2'd0 && fm[f] < w;
         exp_sk.push_back(skp);
         case (k)
            2'd1: begin
               l = (w[3:0] > 4'h9 || dc) ? w[3:0] + 4'h6 : w[3:0];
               h = (w[7:4] > 4'h9 || c) ? w[7:4] + 5'h06 : {1'b0, w[7:4]};
               r = {h[3:0], l};
               c = c | h[4];
               fm[f] = r;
               if (!s) w = r;
            end
            2'd2: r = {fm[f][6:0], fm[f][7]};
            2'd3: begin
               r = {c, fm[f][7:1]};
               c = fm[f][0];
            end
            default: ;
         endcase
         if (k[1] && s) fm[f] = r;
         if (k[1] && !s) w = r;
      end
      cbrop_seq_model_i.issue({k == 2'd0 ? OPC_CMP_LT : k == 2'd1 ? OPC_DADJ :
         k == 2'd2 ? OPC_ROT_L : OPC_ROT_RC, s, f});
   endtask : ex
   // scoreboard: read data one cycle after the strobe, skip at every done
   always @(posedge clk) begin
      rd_q <= rd;
      if (rd_q === 1'b1) begin
         check(rdata, exp_rd.pop_front());
      end
      if (done === 1'b1) begin
         check({7'h00, skip}, {7'h00, exp_sk.pop_front()});
      end
   end
   // main sequence
   initial begin
      logic [7:0] t, f1, f2, v;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rdx(OFS_WORK, WORK_RESET);
      rdx(OFS_STAT, 8'h00);
      rdx(9'h0a5, 8'h00);
      for (int i = 0; i < 300; i++) begin
         w = rnd();
         t = rnd();
         c = t[0];
         dc = t[1];
         bus(1'b1, OFS_WORK, w);
         bus(1'b1, OFS_STAT, {6'h00, dc, c});
         f1 = rnd();
         v = rnd();
         fm[f1] = v;
         bus(1'b1, {1'b1, f1}, v);
         f2 = rnd();
         v = rnd();
         fm[f2] = v;
         bus(1'b1, {1'b1, f2}, v);
         quiet();
         t = rnd();
         ex(t[1:0], t[2], f1);
         ex(t[4:3], t[5], f2);
         cbrop_seq_model_i.release_bus();
         repeat (5) @(posedge clk);
         rdx(OFS_WORK, w);
         rdx(OFS_STAT, {4'h0, skp, 1'b0, dc, c});
         rdx({1'b1, f1}, fm[f1]);
         rdx({1'b1, f2}, fm[f2]);
         quiet();
      end
      repeat (3) @(posedge clk);
      wrap_up();
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      wrap_up();
   end
endmodule : cbrop_core_bench
